// ===== smc_sleep_ctrl.sv
// Overview of operation
// - four states off, normal, enter, sleep; request high is normal, low is sleep.
// - sleep begins a few hundred nanoseconds after a steady low request.
// - request is glitch filtered with hysteresis; defaults high as if pulled up.
// - scan and programming circuitry enabled only in normal and enter states.
// - block RAM and registers are not kept across sleep or off.
// - normal operation resumes after the wake-up interval once request goes high.
`default_nettype none
module smc_sleep_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // power supplies present
  input wire logic power_good,
  // request from the system controller
  input wire logic sleep_request_n,
  // controls to the rest of the device
  output logic user_logic_run,
  output logic user_io_enable,
  output logic test_prog_enable,
  output logic embedded_block_ram_retain,
  output logic user_reinit,
  output logic asleep
);
  smc_pkg::smc_state_e state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic run_q, run_d;
  logic ioen_q, ioen_d;
  logic tpen_q, tpen_d;
  logic reinit_q, reinit_d;
  logic asleep_q, asleep_d;
  logic retain_q, retain_d;
  logic req_filt_n;

  // terminal count of a cycle counter; shared by the entry and wake timers
  function automatic logic cnt_done(input logic [7:0] cnt,
                                    input logic [7:0] lim);
    cnt_done = (cnt == lim - 8'h01);
  endfunction : cnt_done

  smc_glitch_filter u_filter (
    .clk(clk),
    .rst(rst),
    .raw_n(sleep_request_n),
    .filt_n(req_filt_n)
  );

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    reinit_d = 1'b0;
    case (state_q)
      smc_pkg::SMC_OFF: begin
        if (power_good && req_filt_n) begin
          state_d = smc_pkg::SMC_NORMAL;
          reinit_d = 1'b1;
        end else if (power_good) begin
          state_d = smc_pkg::SMC_SLEEP;
        end
      end
      smc_pkg::SMC_NORMAL: begin
        if (!req_filt_n) begin
          state_d = smc_pkg::SMC_ENTER;
          cnt_d = smc_pkg::CNT_ZERO;
        end
      end
      smc_pkg::SMC_ENTER: begin
        if (req_filt_n) begin
          state_d = smc_pkg::SMC_NORMAL;
        end else if (cnt_done(cnt_q, smc_pkg::ENTER_CYC8)) begin
          state_d = smc_pkg::SMC_SLEEP;
          cnt_d = smc_pkg::CNT_ZERO;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      smc_pkg::SMC_SLEEP: begin
        // wake-up interval; a new low restarts it
        if (!req_filt_n) begin
          cnt_d = smc_pkg::CNT_ZERO;
        end else if (cnt_done(cnt_q, smc_pkg::WAKE_CYC8)) begin
          state_d = smc_pkg::SMC_NORMAL;
          cnt_d = smc_pkg::CNT_ZERO;
          reinit_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      default: begin
        state_d = smc_pkg::SMC_OFF;
        cnt_d = smc_pkg::CNT_ZERO;
      end
    endcase
    // losing power drops to off from anywhere
    if (!power_good) begin
      state_d = smc_pkg::SMC_OFF;
      cnt_d = smc_pkg::CNT_ZERO;
      reinit_d = 1'b0;
    end
  end

  // outputs decoded from the next state so they stay registered
  always_comb begin
    // halt and tri-state outside normal; the entry window still runs
    run_d = (state_d == smc_pkg::SMC_NORMAL) ||
            (state_d == smc_pkg::SMC_ENTER);
    ioen_d = run_d;
    // test and programming only in normal and enter
    tpen_d = run_d;
    asleep_d = (state_d == smc_pkg::SMC_SLEEP);
    retain_d = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= smc_pkg::SMC_OFF;
      cnt_q <= smc_pkg::CNT_ZERO;
      run_q <= 1'b0;
      ioen_q <= 1'b0;
      tpen_q <= 1'b0;
      reinit_q <= 1'b0;
      asleep_q <= 1'b0;
      retain_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      ioen_q <= ioen_d;
      tpen_q <= tpen_d;
      reinit_q <= reinit_d;
      asleep_q <= asleep_d;
      retain_q <= retain_d;
    end
  end

  assign user_logic_run = run_q;
  assign user_io_enable = ioen_q;
  assign test_prog_enable = tpen_q;
  // kept as a flop so every output leaves a register
  assign embedded_block_ram_retain = retain_q;
  assign user_reinit = reinit_q;
  assign asleep = asleep_q;
endmodule : smc_sleep_ctrl
`default_nettype wire

// ===== smc_pkg.sv
`default_nettype none
package smc_pkg;
  // glitch filter: a low shorter than this never reaches the state machine
  localparam int FILT_NS = 100;
  localparam int CLK_NS = 5;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] FILT_CYC8 = 8'(FILT_CYC);
  // further delay from filtered low to sleep (several hundred ns total)
  localparam int ENTER_NS = 200;
  localparam int ENTER_CYC = (ENTER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] ENTER_CYC8 = 8'(ENTER_CYC);
  // wake-up interval after the request returns high
  localparam int WAKE_NS = 500;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] WAKE_CYC8 = 8'(WAKE_CYC);
  localparam logic [7:0] CNT_ZERO = 8'h00;

  typedef enum logic [3:0] {
    SMC_OFF    = 4'h1,
    SMC_NORMAL = 4'h2,
    SMC_ENTER  = 4'h4,
    SMC_SLEEP  = 4'h8
  } smc_state_e;
endpackage : smc_pkg
`default_nettype wire

// ===== smc_glitch_filter.sv
`default_nettype none
module smc_glitch_filter (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw and filtered request
  input wire logic raw_n,
  output logic filt_n
);
  logic [7:0] cnt_q, cnt_d;
  logic filt_q, filt_d;

  // a level must hold for FILT_CYC cycles before the output follows it;
  // toggling on both edges gives hysteresis in time
  always_comb begin
    cnt_d = cnt_q;
    filt_d = filt_q;
    if (raw_n == filt_q) begin
      cnt_d = smc_pkg::CNT_ZERO;
    end else if (cnt_q == smc_pkg::FILT_CYC8 - 8'h01) begin
      cnt_d = smc_pkg::CNT_ZERO;
      filt_d = raw_n;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= smc_pkg::CNT_ZERO;
      // defaults to normal, as the pin's pull-up would
      filt_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      filt_q <= filt_d;
    end
  end

  assign filt_n = filt_q;
endmodule : smc_glitch_filter
`default_nettype wire

// ===== smc_props.sv
`default_nettype none
module smc_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs of the block
  input wire logic power_good,
  input wire logic sleep_request_n,
  // outputs of the block
  input wire logic user_logic_run,
  input wire logic user_io_enable,
  input wire logic test_prog_enable,
  input wire logic embedded_block_ram_retain,
  input wire logic user_reinit,
  input wire logic asleep
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_off; !power_good [*2] |=> !user_logic_run && !asleep;
  endproperty
  a_off: assert property (p_off) else $error("not off");
  property p_ent; $rose(asleep) |-> !$past(sleep_request_n, 40);
  endproperty
  a_ent: assert property (p_ent) else $error("early");
  property p_flt; $rose(asleep) |-> !$past(sleep_request_n, 20);
  endproperty
  a_flt: assert property (p_flt) else $error("glitch");
  property p_tst; !user_logic_run |-> !test_prog_enable; endproperty
  a_tst: assert property (p_tst) else $error("test on");
  property p_ini; $rose(user_logic_run) |->
    user_reinit && !embedded_block_ram_retain ##1 !user_reinit;
  endproperty
  a_ini: assert property (p_ini) else $error("reinit");
  property p_wak; $fell(asleep) && power_good |->
    $past(sleep_request_n, 100); endproperty
  a_wak: assert property (p_wak) else $error("wake");
  property p_io; user_io_enable == (user_logic_run && !asleep);
  endproperty
  a_io: assert property (p_io) else $error("io");
  c_slp: cover property ($rose(asleep));
  c_wak: cover property ($fell(asleep));
  c_off: cover property ($fell(power_good));
endmodule : smc_props
bind smc_sleep_ctrl smc_props u_props (.*);
`default_nettype wire

// ===== smc_ctrl_model.sv
`default_nettype none
module smc_ctrl_model (
  input wire logic clk,
  output var logic req_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // rests high, as the pull-up would leave it
  initial req_n = 1'b1;
  task automatic hold(input logic lvl, input int n);
    @(negedge clk);
    req_n = lvl;
    repeat (n) @(negedge clk);
  endtask : hold
endmodule : smc_ctrl_model
`default_nettype wire

// ===== smc_tb.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, power_good, run, io, tp, ram, ini, slp;
  wire logic req_n;
  wire logic [5:0] obs = {ram, run, io, tp, slp, ini};
  int fail_count = 0;
  int n_tests = 0;
  smc_ctrl_model m (.clk(clk), .req_n(req_n));
  smc_sleep_ctrl dut (.clk(clk), .rst(rst), .power_good(power_good),
    .sleep_request_n(req_n), .user_logic_run(run), .user_io_enable(io),
    .test_prog_enable(tp), .embedded_block_ram_retain(ram),
    .user_reinit(ini), .asleep(slp));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    power_good = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(obs, 6'h1D);
    m.hold(1'b0, 10);
    m.hold(1'b1, 80);
    chk(obs, 6'h1C);
    // a filtered low cut short during entry must not reach sleep
    m.hold(1'b0, 30);
    m.hold(1'b1, 60);
    chk(obs, 6'h1C);
    m.hold(1'b0, 50);
    chk(obs, 6'h1C);
    m.hold(1'b0, 20);
    chk(obs, 6'h02);
    m.hold(1'b1, 110);
    chk(obs, 6'h02);
    for (int i = 0; i < 30 && run !== 1'b1; i++) @(negedge clk);
    chk(obs, 6'h1D);
    @(negedge clk);
    chk(obs, 6'h1C);
    power_good = 1'b0;
    repeat (3) @(negedge clk);
    chk(obs, 6'h00);
    // power returning with the request low goes straight to sleep
    m.hold(1'b0, 25);
    power_good = 1'b1;
    @(negedge clk);
    chk(obs, 6'h02);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
